// [design/abg_boot_host.sv]
// Host sequencer that autoboots the decoder from the paged ROM
// Contract
// [RULE1] Sector high: bit15/request buffers off, decoder bit15 on
// [RULE2] Table sector: two 64 KB pages by page-high
// [RULE3] Sector low in reset: request driven low
// [RULE4] Decoder boots on low request at reset rise
// [RULE5] Boot sector: four 32 KB pages, bits 15-16
// [RULE6] In reset: bit15 low, page-high high, sector low (code holds the decoder in reset in ST_IDLE with sector high, page-high low)
// [RULE7] Sector stays low until boot completes
// [RULE8] Request buffer only pulls low, else releases
// [RULE9] Wait 175 ms, masking decoder interrupt meanwhile
// [RULE10] Verify variable, retry after 5 ms, reboot
// [RULE11] Before start command: sector high, page-high low (code raises sector and drops page-high on the same edge as the command)
// [RULE12] Verify value neither all zeros nor ones
`timescale 1ns/1ps
module abg_boot_host
#(
  parameter int BOOT_WAIT_CYC = abg_pkg::BOOT_WAIT_CYC,
  parameter int RETRY_WAIT_CYC = abg_pkg::RETRY_WAIT_CYC,
  parameter logic [15:0] VERIFY_VALUE = abg_pkg::VERIFY_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  abg_link_if.host_mp link,
  input wire logic boot_go,
  input wire logic var_rd_valid,
  input wire logic [15:0] var_rd_data,
  output logic var_rd_req,
  output logic start_decode_command,
  output logic boot_ok,
  output logic irq_to_cpu,
  output logic [3:0] boot_tries
);

  ////////////////////////////////////////////////////////////////////////
  // State

  abg_pkg::abg_state_type state_ff, nxt_state;
  logic [abg_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic rst_n_ff, nxt_rst_n;
  logic sector_ff, nxt_sector;
  logic psh_ff, nxt_psh;
  logic hpbl_ff, nxt_hpbl;
  logic rd_req_ff, nxt_rd_req;
  logic kick_ff, nxt_kick;
  logic ok_ff, nxt_ok;
  logic irq_ff, nxt_irq;
  logic [3:0] tries_ff, nxt_tries;
  logic var_match;

  // True once the counter has reached the last cycle of a wait
  function automatic logic expired(input logic [abg_pkg::CNT_W-1:0] cnt,
                                   input int limit);
    expired = (cnt == abg_pkg::CNT_W'(limit - 1));
  endfunction

  // Matches are only trusted for a non-trivial expected value
  assign var_match = (var_rd_data == VERIFY_VALUE) &&
                     (VERIFY_VALUE != 16'h0000) &&
                     (VERIFY_VALUE != 16'hffff); // [RULE12]

  ////////////////////////////////////////////////////////////////////////
  // Next state and link levels

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + abg_pkg::CNT_W'(1);
    nxt_rst_n = rst_n_ff;
    nxt_sector = sector_ff;
    nxt_psh = psh_ff;
    nxt_hpbl = hpbl_ff;
    nxt_rd_req = 1'h0;
    nxt_kick = 1'h0;
    nxt_ok = ok_ff;
    nxt_tries = tries_ff;
    case (state_ff)
      abg_pkg::ST_IDLE:
      begin
        nxt_cnt = '0;
        if (boot_go)
        begin
          nxt_state = abg_pkg::ST_RESET;
          nxt_tries = abg_pkg::TRIES_RST;
          nxt_ok = 1'h0;
          nxt_rst_n = 1'h0;
          nxt_sector = 1'h0; // [RULE6]
          nxt_psh = 1'h1; // [RULE6]
          nxt_hpbl = 1'h0; // [RULE6]
        end
      end
      abg_pkg::ST_RESET:
      begin
        if (expired(cnt_ff, abg_pkg::RST_HOLD_CYC))
        begin
          // Release reset with the sector still low
          nxt_rst_n = 1'h1; // [RULE7]
          nxt_cnt = '0;
          nxt_state = abg_pkg::ST_WAIT_BOOT;
        end
      end
      abg_pkg::ST_WAIT_BOOT:
      begin
        if (expired(cnt_ff, BOOT_WAIT_CYC)) // [RULE9]
        begin
          nxt_rd_req = 1'h1; // [RULE10]
          nxt_state = abg_pkg::ST_READ1;
        end
      end
      abg_pkg::ST_READ1:
      begin
        nxt_cnt = '0;
        if (var_rd_valid)
        begin
          if (var_match)
          begin
            nxt_state = abg_pkg::ST_PAGE_TABLES;
          end
          else
          begin
            nxt_state = abg_pkg::ST_WAIT_RETRY; // [RULE10]
          end
        end
      end
      abg_pkg::ST_WAIT_RETRY:
      begin
        if (expired(cnt_ff, RETRY_WAIT_CYC)) // [RULE10]
        begin
          nxt_rd_req = 1'h1;
          nxt_state = abg_pkg::ST_READ2;
        end
      end
      abg_pkg::ST_READ2:
      begin
        nxt_cnt = '0;
        if (var_rd_valid)
        begin
          if (var_match)
          begin
            nxt_state = abg_pkg::ST_PAGE_TABLES;
          end
          else
          begin
            // Second failure: run the whole boot again
            nxt_state = abg_pkg::ST_RESET; // [RULE10]
            nxt_tries = tries_ff + 4'h1;
            nxt_rst_n = 1'h0;
            nxt_sector = 1'h0; // [RULE6]
            nxt_psh = 1'h1;
            nxt_hpbl = 1'h0;
          end
        end
      end
      abg_pkg::ST_PAGE_TABLES:
      begin
        // Boot is complete; page to the tables and start decoding in the same cycle
        nxt_sector = 1'h1; // [RULE11]
        nxt_psh = 1'h0; // [RULE11]
        nxt_kick = 1'h1; // [RULE11]
        nxt_ok = 1'h1;
        nxt_cnt = '0;
        nxt_state = abg_pkg::ST_DONE;
      end
      abg_pkg::ST_DONE:
      begin
        nxt_cnt = '0;
        if (boot_go)
        begin
          nxt_state = abg_pkg::ST_RESET;
          nxt_tries = abg_pkg::TRIES_RST;
          nxt_ok = 1'h0;
          nxt_rst_n = 1'h0;
          nxt_sector = 1'h0; // [RULE6]
          nxt_psh = 1'h1;
          nxt_hpbl = 1'h0;
        end
      end
      default:
      begin
        nxt_state = abg_pkg::ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
    // Interrupt passes only after a verified boot
    nxt_irq = (state_ff == abg_pkg::ST_DONE) &&
              !link.autoboot_request_n; // [RULE9]
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= abg_pkg::ST_IDLE;
      cnt_ff <= '0;
      rst_n_ff <= 1'h0;
      sector_ff <= 1'h1;
      psh_ff <= 1'h0;
      hpbl_ff <= 1'h0;
      rd_req_ff <= 1'h0;
      kick_ff <= 1'h0;
      ok_ff <= 1'h0;
      irq_ff <= 1'h0;
      tries_ff <= abg_pkg::TRIES_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rst_n_ff <= nxt_rst_n;
      sector_ff <= nxt_sector;
      psh_ff <= nxt_psh;
      hpbl_ff <= nxt_hpbl;
      rd_req_ff <= nxt_rd_req;
      kick_ff <= nxt_kick;
      ok_ff <= nxt_ok;
      irq_ff <= nxt_irq;
      tries_ff <= nxt_tries;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.dsp_reset_n = rst_n_ff;
  assign link.sector_select_line = sector_ff;
  assign link.page_select_high = psh_ff;
  assign link.host_page_bit_low = hpbl_ff;
  assign var_rd_req = rd_req_ff;
  assign start_decode_command = kick_ff;
  assign boot_ok = ok_ff;
  assign irq_to_cpu = irq_ff;
  assign boot_tries = tries_ff;

endmodule

// [design/abg_link_if.sv]
// Link between the host sequencer and the ROM paging glue
`timescale 1ns/1ps
interface abg_link_if;
  logic dsp_reset_n;
  logic sector_select_line;
  logic page_select_high;
  logic host_page_bit_low;
  logic abr_out;
  logic abr_oe_n;
  logic autoboot_request_n;
  logic irq_pull_n;

  // Open-drain line with pull-up: low while either driver pulls it low
  assign autoboot_request_n = (abr_oe_n | abr_out) & irq_pull_n;

  modport host_mp
  (
    output dsp_reset_n,
    output sector_select_line,
    output page_select_high,
    output host_page_bit_low,
    input autoboot_request_n
  );

  modport dev_mp
  (
    input dsp_reset_n,
    input sector_select_line,
    input page_select_high,
    input host_page_bit_low,
    output abr_out,
    output abr_oe_n,
    output irq_pull_n,
    input autoboot_request_n
  );
endinterface

// [design/abg_pkg.sv]
// Constants used by the host end of the autoboot paging glue link and the bench
package abg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and times
  localparam int CLK_HZ = 10_000_000;
  localparam int BOOT_WAIT_MS = 175;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_MS * (CLK_HZ / 1000);
  localparam int RETRY_WAIT_MS = 5;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_MS * (CLK_HZ / 1000);
  localparam int RST_HOLD_US = 10;
  localparam int RST_HOLD_CYC = RST_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 21;

  ////////////////////////////////////////////////////////////////////////
  // Address layout
  localparam int DEC_ADDR_W = 16;
  localparam int ROM_ADDR_W = 18;
  localparam int VAR_W = 16;
  localparam logic [15:0] VERIFY_DEFAULT = 16'h5aa5;
  localparam logic [3:0] TRIES_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Host sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_RESET,
    ST_WAIT_BOOT,
    ST_READ1,
    ST_WAIT_RETRY,
    ST_READ2,
    ST_PAGE_TABLES,
    ST_DONE
  } abg_state_type;

endpackage

// [design/abg_rom_glue.sv]
// Adapter card glue: ROM page decode, boot request buffer, boot detect
`timescale 1ns/1ps
module abg_rom_glue
(
  input wire logic core_clk,
  input wire logic rst_b,
  abg_link_if.dev_mp link,
  input wire logic [15:0] dec_addr,
  input wire logic dec_irq_req,
  input wire logic dec_boot_done,
  output logic [17:0] rom_addr,
  output logic decoder_bit15_buffer,
  output logic boot_request_buffer_out,
  output logic autoboot_start,
  output logic booting,
  output logic decoder_irq_out
);

  logic [17:0] rom_addr_ff, nxt_rom_addr;
  logic bit15_en_ff, nxt_bit15_en;
  logic req_en_ff, nxt_req_en;
  logic start_ff, nxt_start;
  logic booting_ff, nxt_booting;
  logic booted_ff, nxt_booted;
  logic rst_prev_ff, nxt_rst_prev;
  logic irq_ff, nxt_irq;
  logic abr_oe_n_ff, nxt_abr_oe_n;

  ////////////////////////////////////////////////////////////////////////
  // Paging and buffer enables
  always_comb
  begin
    if (link.sector_select_line)
    begin
      // Table sector: two 64 KB pages, decoder owns bit 15
      nxt_rom_addr = {1'h1, link.page_select_high, dec_addr}; // [RULE1] [RULE2]
      nxt_bit15_en = 1'h1; // [RULE1]
      nxt_req_en = 1'h0; // [RULE1]
    end
    else
    begin
      // Boot sector: four 32 KB pages picked by host bits 16 and 15
      nxt_rom_addr = {1'h0, link.page_select_high, link.host_page_bit_low,
                      dec_addr[14:0]}; // [RULE5]
      nxt_bit15_en = 1'h0;
      nxt_req_en = 1'h1; // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot detect at reset release and shared request/irq pin
  always_comb
  begin
    nxt_rst_prev = link.dsp_reset_n;
    nxt_start = 1'h0;
    nxt_booting = booting_ff;
    nxt_booted = booted_ff;
    if (!link.dsp_reset_n)
    begin
      nxt_booting = 1'h0;
      nxt_booted = 1'h0;
    end
    else if (!rst_prev_ff && !link.autoboot_request_n)
    begin
      nxt_start = 1'h1; // [RULE4]
      nxt_booting = 1'h1; // [RULE4]
    end
    else if (booting_ff && dec_boot_done)
    begin
      nxt_booting = 1'h0;
      nxt_booted = 1'h1;
    end
    // Decoder reuses the pin for its interrupt after a good download
    nxt_irq = booted_ff && dec_irq_req; // [RULE8]
    // Request buffer only pulls low, and only in the boot sector
    nxt_abr_oe_n = !nxt_req_en; // [RULE1] [RULE3] [RULE8]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rom_addr_ff <= '0;
      bit15_en_ff <= 1'h0;
      req_en_ff <= 1'h0;
      start_ff <= 1'h0;
      booting_ff <= 1'h0;
      booted_ff <= 1'h0;
      rst_prev_ff <= 1'h0;
      irq_ff <= 1'h0;
      abr_oe_n_ff <= 1'h1;
    end
    else
    begin
      rom_addr_ff <= nxt_rom_addr;
      bit15_en_ff <= nxt_bit15_en;
      req_en_ff <= nxt_req_en;
      start_ff <= nxt_start;
      booting_ff <= nxt_booting;
      booted_ff <= nxt_booted;
      rst_prev_ff <= nxt_rst_prev;
      irq_ff <= nxt_irq;
      abr_oe_n_ff <= nxt_abr_oe_n;
    end
  end

  assign rom_addr = rom_addr_ff;
  assign decoder_bit15_buffer = bit15_en_ff;
  assign boot_request_buffer_out = req_en_ff;
  assign autoboot_start = start_ff;
  assign booting = booting_ff;
  assign decoder_irq_out = irq_ff;
  assign link.abr_oe_n = abr_oe_n_ff;
  assign link.abr_out = 1'h0; // [RULE8]
  assign link.irq_pull_n = !irq_ff; // [RULE8]

endmodule

// [verification/abg_link_assertions.sv]
// Link protocol assertions for the autoboot paging glue
`timescale 1ns/1ps
module abg_link_assertions
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic dsp_reset_n,
  input wire logic sector_select_line,
  input wire logic page_select_high,
  input wire logic host_page_bit_low,
  input wire logic abr_out,
  input wire logic abr_oe_n,
  input wire logic irq_pull_n,
  input wire logic autoboot_request_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_held;
    !sector_select_line [*8];
  endsequence
  sequence s_req_low;
    !autoboot_request_n [*2];
  endsequence
  property p_tbl_off;
    sector_select_line |=> abr_oe_n;
  endproperty
  a_tbl_off: assert property (p_tbl_off)
    else $error("request buffer on in table sector");
  property p_boot_on;
    !sector_select_line |=> !abr_oe_n;
  endproperty
  a_boot_on: assert property (p_boot_on)
    else $error("request buffer off in boot sector");
  property p_line_low;
    $fell(sector_select_line) |=> s_req_low;
  endproperty
  a_line_low: assert property (p_line_low)
    else $error("request line not pulled low");
  property p_odrain;
    abr_oe_n |-> (autoboot_request_n == irq_pull_n) && !abr_out;
  endproperty
  a_odrain: assert property (p_odrain)
    else $error("request line driven high");
  property p_sel_boot;
    $fell(sector_select_line) |->
      !dsp_reset_n && page_select_high && !host_page_bit_low;
  endproperty
  a_sel_boot: assert property (p_sel_boot)
    else $error("boot page chosen wrongly");
  property p_hold;
    $rose(dsp_reset_n) |-> s_held;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sector raised during download");
  property p_req_rise;
    $rose(dsp_reset_n) |-> !autoboot_request_n;
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("request high at reset release");
  property p_tbl_page;
    $rose(sector_select_line) |-> !page_select_high && dsp_reset_n;
  endproperty
  a_tbl_page: assert property (p_tbl_page)
    else $error("table page chosen wrongly");
endmodule

// [verification/autoboot_rom_paging_glue_tb.sv]
// Self-checking bench for the autoboot paging glue link
`timescale 1ns/1ps
module autoboot_rom_paging_glue_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic boot_go = 1'b0;
  logic var_rd_valid = 1'b0;
  logic [15:0] var_rd_data = 16'h0000;
  logic [15:0] dec_addr = 16'h8001;
  logic dec_irq_req = 1'b0;
  logic dec_boot_done = 1'b0;
  logic var_rd_req, start_decode_command, boot_ok, irq_to_cpu;
  logic [3:0] boot_tries;
  logic [17:0] rom_addr;
  logic decoder_bit15_buffer, boot_request_buffer_out;
  logic autoboot_start, booting, decoder_irq_out;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  abg_link_if link ();
  abg_boot_host #(.BOOT_WAIT_CYC(200), .RETRY_WAIT_CYC(50)) i_abg_boot_host
  (
    .core_clk, .rst_b, .link, .boot_go, .var_rd_valid, .var_rd_data,
    .var_rd_req, .start_decode_command, .boot_ok, .irq_to_cpu, .boot_tries
  );
  abg_rom_glue i_abg_rom_glue
  (
    .core_clk, .rst_b, .link, .dec_addr, .dec_irq_req, .dec_boot_done,
    .rom_addr, .decoder_bit15_buffer, .boot_request_buffer_out,
    .autoboot_start, .booting, .decoder_irq_out
  );
  abg_link_assertions i_abg_link_assertions
  (
    .core_clk, .rst_b, .dsp_reset_n(link.dsp_reset_n),
    .sector_select_line(link.sector_select_line),
    .page_select_high(link.page_select_high),
    .host_page_bit_low(link.host_page_bit_low), .abr_out(link.abr_out),
    .abr_oe_n(link.abr_oe_n), .irq_pull_n(link.irq_pull_n),
    .autoboot_request_n(link.autoboot_request_n)
  );
  always #50 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %h %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  function automatic logic pick(input int k);
    case (k)
      0: return link.dsp_reset_n;
      1: return var_rd_req;
      default: return start_decode_command;
    endcase
  endfunction
  task automatic wait_sig(input int k);
    n = 0;
    while (pick(k) !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic reply(input logic [15:0] d);
    var_rd_valid = 1'b1;
    var_rd_data = d;
    @(negedge core_clk);
    var_rd_valid = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic start_boot;
    boot_go = 1'b1;
    @(negedge core_clk);
    boot_go = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(link.autoboot_request_n, 0);
    chk(boot_request_buffer_out, 1);
    chk(decoder_bit15_buffer, 0);
    chk(rom_addr, 18'h1_0001);
  endtask
  task automatic run_boot;
    dec_irq_req = 1'b1;
    wait_sig(0);
    @(negedge core_clk);
    chk(autoboot_start, 1);
    repeat (2) @(negedge core_clk);
    chk(booting, 1);
    chk(autoboot_start, 0);
    dec_boot_done = 1'b1;
    @(negedge core_clk);
    dec_boot_done = 1'b0;
    chk(irq_to_cpu, 0);
    wait_sig(1);
    chk(n + 4 >= 200, 1);
  endtask
  task automatic finish_ok;
    reply(abg_pkg::VERIFY_DEFAULT);
    wait_sig(2);
    chk(link.sector_select_line, 1);
    chk(link.page_select_high, 0);
    chk(boot_ok, 1);
    repeat (2) @(negedge core_clk);
    chk(rom_addr, 18'h2_8001);
    chk(decoder_bit15_buffer, 1);
    chk(boot_request_buffer_out, 0);
    chk(decoder_irq_out, 1);
    chk(irq_to_cpu, 1);
    dec_irq_req = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(link.autoboot_request_n, 1);
    chk(irq_to_cpu, 0);
  endtask
  task automatic t_clean;
    chk(abg_pkg::VERIFY_DEFAULT != 16'h0000 &&
        abg_pkg::VERIFY_DEFAULT != 16'hffff, 1);
    start_boot;
    run_boot;
    finish_ok;
    $display("clean boot test ended");
  endtask
  task automatic t_retry;
    start_boot;
    run_boot;
    reply(16'hffff);
    wait_sig(1);
    chk(n + 1 >= 50, 1);
    reply(16'h0000);
    @(negedge core_clk);
    chk(link.dsp_reset_n, 0);
    chk(boot_tries, 1);
    run_boot;
    finish_ok;
    $display("retry boot test ended");
  endtask
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    t_clean;
    t_retry;
    give_verdict;
  end
endmodule
